// file: src/swbm_pkg.sv
package swbm_pkg;
    localparam int unsigned CLK_HZ = 25_000_000;
    localparam int unsigned TOUT_MS = 20;
    localparam int unsigned TOUT_CYC = CLK_HZ / 1000 * TOUT_MS;
    localparam int unsigned WUF_US = 40;
    localparam int unsigned WUF_CYC = CLK_HZ / 1_000_000 * WUF_US;
    localparam int unsigned SLEEP_MS = 300;
    localparam int unsigned SLEEP_CYC = CLK_HZ / 1000 * SLEEP_MS;
    localparam int CNT_W = 24;
    localparam logic [1:0] MODE_SLEEP = 2'h0;
    localparam logic [1:0] MODE_HS = 2'h1;
    localparam logic [1:0] MODE_HIGH_VOLTAGE_WAKEUP = 2'h2;
    localparam logic [1:0] MODE_NORM = 2'h3;
    typedef enum logic [1:0] {
        ST_SLEEP,
        ST_STANDBY,
        ST_ACTIVE
    } swbm_state_t;
endpackage

// file: src/swbm_sync.sv
`timescale 1ns/1ps
module swbm_sync #(
    parameter int W = 1
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] s1_r;
    logic [W-1:0] s1_nxt;
    logic [W-1:0] q_r;
    logic [W-1:0] q_nxt;
    always_comb
    begin
        s1_nxt = ce ? d : s1_r;
        q_nxt = ce ? s1_r : q_r;
    end
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s1_r <= '0;
            q_r <= '0;
        end
        else
        begin
            s1_r <= s1_nxt;
            q_r <= q_nxt;
        end
    end
    assign q = q_r;
endmodule // swbm_sync

// file: src/swbm_buf2.sv
`timescale 1ns/1ps
module swbm_buf2 #(
    parameter int W = 1
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    // two entries so a stall loses no sample
    logic [W-1:0] mem_r [2];
    logic [W-1:0] mem_nxt [2];
    logic [1:0] cnt_r;
    logic [1:0] cnt_nxt;
    logic rd_r;
    logic rd_nxt;
    logic wr_r;
    logic wr_nxt;
    logic push;
    logic pop;
    always_comb
    begin
        push = ce && in_valid && (cnt_r != 2'h2);
        pop = ce && out_ready && (cnt_r != 2'h0);
        mem_nxt = mem_r;
        if (push)
            mem_nxt[wr_r] = in_data;
        wr_nxt = push ? ~wr_r : wr_r;
        rd_nxt = pop ? ~rd_r : rd_r;
        cnt_nxt = cnt_r + {1'b0, push} - {1'b0, pop};
    end
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            mem_r[0] <= '1;
            mem_r[1] <= '1;
            cnt_r <= 2'h0;
            rd_r <= 1'b0;
            wr_r <= 1'b0;
        end
        else
        begin
            mem_r <= mem_nxt;
            cnt_r <= cnt_nxt;
            rd_r <= rd_nxt;
            wr_r <= wr_nxt;
        end
    end
    assign in_ready = (cnt_r != 2'h2);
    assign out_valid = (cnt_r != 2'h0);
    assign out_data = mem_r[rd_r];
endmodule // swbm_buf2

// file: src/swbm_core.sv
`timescale 1ns/1ps
// Summary of operation
// (R1) transmit high or floating leaves the bus undriven, recessive.
// (R2) transmit low drives dominant, normal or raised level by mode.
// (R3) sleep never drives the bus dominant.
// (R4) transmit input has a pull-up; undriven means recessive.
// (R5) transmit low beyond time-out switches the driver off.
// (R6) time-out reaction time lies between 10 ms and 30 ms.
// (R7) after time-out, next transmit rising edge resumes with no delay.
// (R8) mode inputs pulled low; undriven means sleep.
// (R9) modes: LL sleep, HL high-speed, LH wake-up, HH normal.
// (R10) sleep is left on valid wake-up or mode change off LL.
// (R11) high-speed mode disables wave shaping, up to 100 kbit/s.
// (R12) wake-up mode drives dominant at raised voltage.
// (R13) controller sends 33.333 kbit/s in normal mode; shaping applied.
// (R14) receive high when recessive, low when any dominant level.
// (R15) sleep passes no bus activity to receive output.
// (R16) valid wake-up from sleep drives receive low as interrupt.
// (R17) wake-up valid only after high level persists 10 to 70 us.
// (R18) no mode change after wake-up returns to sleep on its own.
// (R19) standby-to-sleep return takes between 100 ms and 500 ms.
// (R20) outside sleep, all valid bus changes reach receive output; code passes them in active state only, not in standby.
// (R21) load ground path stays closed unless loss of ground detected.
// (R22) transmit, mode and bus inputs synchronised before use.
// (R23) time-out counter restarts on falling edge, clears when high.
module swbm_core
    import swbm_pkg::*;
#(
    parameter int unsigned TOUT_CYCLES = TOUT_CYC,
    parameter int unsigned WUF_CYCLES = WUF_CYC,
    parameter int unsigned SLEEP_CYCLES = SLEEP_CYC
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic tx_cmd_n,
    input wire logic tx_cmd_pu_sense,
    input wire logic mode_select_first,
    input wire logic mode_select_second,
    input wire logic bus_dom_sense,
    input wire logic bus_hv_sense,
    input wire logic gnd_loss,
    output logic bus_line_o,
    output logic bus_line_oe,
    output logic bus_hv_level,
    output logic wave_shape_en,
    output logic rx_data,
    output logic load_gnd_on,
    output logic inh_on,
    output logic timeout_flag,
    output logic [1:0] mode_now
);
    import swbm_pkg::*;

    logic [5:0] raw;
    logic [5:0] syn;
    logic tx_act_s;
    logic tx_s;
    logic m0_s;
    logic m1_s;
    logic dom_s;
    logic hv_s;
    logic gnd_s;
    logic [1:0] msel;
    // tx read as high if undriven (pull-up modelled by sense pin)
    // tx rides inverted so the all-zero sync reset reads as idle
    assign raw = {~(tx_cmd_n | ~tx_cmd_pu_sense), // [R4]
                  mode_select_first, mode_select_second,
                  bus_dom_sense, bus_hv_sense, gnd_loss};
    // ground detector is asynchronous too, so it shares the sync
    swbm_sync #(.W(6)) u_sync (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .ce(ce),
        .d(raw),
        .q(syn)
    ); // [R22]
    // sync resets to zero; undriven mode inputs already mean sleep [R8]
    assign {tx_act_s, m0_s, m1_s, dom_s, hv_s, gnd_s} = syn;
    assign tx_s = ~tx_act_s;
    assign msel = {m1_s, m0_s}; // [R9]

    swbm_state_t st_r;
    swbm_state_t st_nxt;
    logic [CNT_W-1:0] sl_cnt_r;
    logic [CNT_W-1:0] sl_cnt_nxt;
    logic [CNT_W-1:0] wu_cnt_r;
    logic [CNT_W-1:0] wu_cnt_nxt;
    logic wu_flag_r;
    logic wu_flag_nxt;
    logic wu_valid;
    // filter runs in every state; only sleep acts on it
    assign wu_valid = (wu_cnt_r >= CNT_W'(WUF_CYCLES)); // [R17]

    always_comb
    begin
        st_nxt = st_r;
        sl_cnt_nxt = sl_cnt_r;
        wu_flag_nxt = wu_flag_r;
        wu_cnt_nxt = hv_s ? (wu_valid ? wu_cnt_r : wu_cnt_r + 1'b1)
                          : '0; // [R17]
        case (st_r)
            ST_SLEEP:
            begin
                if (msel != MODE_SLEEP)
                    st_nxt = ST_ACTIVE; // [R10]
                else if (wu_valid)
                begin
                    st_nxt = ST_STANDBY; // [R10]
                    sl_cnt_nxt = '0;
                    wu_flag_nxt = 1'b1; // [R16]
                end
            end
            ST_STANDBY:
            begin
                // a mode change stops the sleep timer
                if (!hv_s)
                    wu_flag_nxt = 1'b0;
                if (msel != MODE_SLEEP)
                begin
                    st_nxt = ST_ACTIVE;
                    wu_flag_nxt = 1'b0;
                end
                else if (sl_cnt_r >= CNT_W'(SLEEP_CYCLES - 1))
                begin
                    st_nxt = ST_SLEEP; // [R18] [R19]
                    wu_flag_nxt = 1'b0;
                end
                else
                    sl_cnt_nxt = sl_cnt_r + 1'b1;
            end
            ST_ACTIVE:
            begin
                if (msel == MODE_SLEEP)
                    st_nxt = ST_SLEEP;
            end
            default:
                st_nxt = ST_SLEEP;
        endcase
        if (!ce)
        begin
            st_nxt = st_r;
            sl_cnt_nxt = sl_cnt_r;
            wu_cnt_nxt = wu_cnt_r;
            wu_flag_nxt = wu_flag_r;
        end
    end

    // standby after power-on, as a wake-up without the interrupt
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_r <= ST_STANDBY;
            sl_cnt_r <= '0;
            wu_cnt_r <= '0;
            wu_flag_r <= 1'b0;
        end
        else
        begin
            st_r <= st_nxt;
            sl_cnt_r <= sl_cnt_nxt;
            wu_cnt_r <= wu_cnt_nxt;
            wu_flag_r <= wu_flag_nxt;
        end
    end

    // dominant time-out
    logic tx_d_r;
    logic tx_d_nxt;
    logic [CNT_W-1:0] to_cnt_r;
    logic [CNT_W-1:0] to_cnt_nxt;
    logic to_r;
    logic to_nxt;
    logic tx_fall;
    assign tx_fall = tx_d_r && !tx_s; // [R23]
    // counter parks at its limit; flag holds until tx rises
    always_comb
    begin
        tx_d_nxt = tx_s;
        to_cnt_nxt = to_cnt_r;
        to_nxt = to_r;
        if (tx_s)
        begin
            to_cnt_nxt = '0; // [R23]
            to_nxt = 1'b0; // [R7]
        end
        else if (tx_fall)
            to_cnt_nxt = '0; // [R23]
        else if (to_cnt_r >= CNT_W'(TOUT_CYCLES - 1))
            to_nxt = 1'b1; // [R5] [R6]
        else
            to_cnt_nxt = to_cnt_r + 1'b1;
        if (!ce)
        begin
            tx_d_nxt = tx_d_r;
            to_cnt_nxt = to_cnt_r;
            to_nxt = to_r;
        end
    end
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            tx_d_r <= 1'b1;
            to_cnt_r <= '0;
            to_r <= 1'b0;
        end
        else
        begin
            tx_d_r <= tx_d_nxt;
            to_cnt_r <= to_cnt_nxt;
            to_r <= to_nxt;
        end
    end

    // receive path through the two-entry buffer
    // always ready, so it never stalls; costs one cycle of latency
    logic rx_cand;
    logic bv;
    logic bd;
    always_comb
    begin
        if (st_r == ST_ACTIVE)
            rx_cand = ~dom_s; // [R14] [R20]
        else if (wu_flag_r)
            rx_cand = 1'b0; // [R16]
        else
            rx_cand = 1'b1; // [R15]
    end
    swbm_buf2 #(.W(1)) u_buf (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .ce(ce),
        .in_valid(1'b1),
        .in_ready(),
        .in_data(rx_cand),
        .out_valid(bv),
        .out_ready(1'b1),
        .out_data(bd)
    );

    // output registers
    logic drv_nxt;
    logic hv_nxt;
    logic sh_nxt;
    logic rx_nxt;
    logic bus_o_r;
    logic bus_oe_r;
    logic hv_r;
    logic sh_r;
    logic rx_r;
    logic gnd_r;
    logic inh_r;
    logic [1:0] md_r;
    logic drv_ok;
    // live mode checked too, so a move to sleep cuts drive at once
    assign drv_ok = (st_r == ST_ACTIVE) && (msel != MODE_SLEEP); // [R3]
    always_comb
    begin
        drv_nxt = drv_ok && !tx_s && !to_r; // [R1] [R2] [R5]
        // raised level only while driving, never on a released bus
        hv_nxt = drv_nxt && (msel == MODE_HIGH_VOLTAGE_WAKEUP); // [R2] [R12]
        sh_nxt = (msel == MODE_NORM) || (msel == MODE_HIGH_VOLTAGE_WAKEUP); // [R11] [R13]
        rx_nxt = bv ? bd : rx_r;
    end
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            bus_o_r <= 1'b0;
            bus_oe_r <= 1'b0;
            hv_r <= 1'b0;
            sh_r <= 1'b0;
            rx_r <= 1'b1;
            gnd_r <= 1'b1;
            inh_r <= 1'b1;
            md_r <= MODE_SLEEP;
        end
        else if (ce)
        begin
            // released pin means recessive, so enable follows the drive
            bus_o_r <= drv_nxt;
            bus_oe_r <= drv_nxt;
            hv_r <= hv_nxt;
            sh_r <= sh_nxt;
            rx_r <= rx_nxt;
            gnd_r <= !gnd_s; // [R21]
            inh_r <= (st_nxt != ST_SLEEP);
            md_r <= msel;
        end
    end
    assign bus_line_o = bus_o_r;
    assign bus_line_oe = bus_oe_r;
    assign bus_hv_level = hv_r;
    assign wave_shape_en = sh_r;
    assign rx_data = rx_r;
    assign load_gnd_on = gnd_r;
    assign inh_on = inh_r;
    assign timeout_flag = to_r;
    assign mode_now = md_r;
endmodule // swbm_core

// file: bench/swbm_checker.sv
`timescale 1ns/1ps
module swbm_checker
    import swbm_pkg::*;
#(
    parameter int unsigned TOUT_CYCLES = 50
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic tx_cmd_n,
    input wire logic tx_cmd_pu_sense,
    input wire logic bus_dom_sense,
    input wire logic gnd_loss,
    input wire logic bus_line_oe,
    input wire logic bus_hv_level,
    input wire logic wave_shape_en,
    input wire logic rx_data,
    input wire logic load_gnd_on,
    input wire logic inh_on,
    input wire logic timeout_flag,
    input wire logic [1:0] mode_now
);
    logic [15:0] lo_r;
    logic [15:0] lo_nxt;
    logic tx_lo;
    assign tx_lo = !tx_cmd_n && tx_cmd_pu_sense;
    // raw pin count; design sees it two cycles later
    always_comb
    begin
        lo_nxt = tx_lo ? lo_r + 16'h0001 : 16'h0000;
    end
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            lo_r <= 16'h0000;
        else
            lo_r <= lo_nxt;
    end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    property p_rec; (!tx_lo)[*5] |-> !bus_line_oe; endproperty
    a_rec: assert property (p_rec) else $error("driving while idle");
    property p_dom;
        (tx_lo && mode_now == MODE_NORM)[*5] ##0 !timeout_flag
            |-> bus_line_oe;
    endproperty
    a_dom: assert property (p_dom) else $error("no dominant drive");
    property p_slp; !inh_on |-> !bus_line_oe; endproperty
    a_slp: assert property (p_slp) else $error("drive in sleep");
    property p_tout; lo_r > TOUT_CYCLES + 6 |-> !bus_line_oe; endproperty
    a_tout: assert property (p_tout) else $error("no time-out");
    property p_early; $rose(timeout_flag) |-> lo_r >= TOUT_CYCLES; endproperty
    a_early: assert property (p_early) else $error("early time-out");
    property p_hv;
        (mode_now == MODE_HIGH_VOLTAGE_WAKEUP)[*4] ##0 bus_line_oe |-> bus_hv_level;
    endproperty
    a_hv: assert property (p_hv) else $error("no raised level");
    property p_nrm; (mode_now == MODE_NORM)[*3] |-> wave_shape_en; endproperty
    a_nrm: assert property (p_nrm) else $error("shaping off");
    property p_rx;
        (mode_now == MODE_NORM && bus_dom_sense)[*6] |-> !rx_data;
    endproperty
    a_rx: assert property (p_rx) else $error("rx not low");
    property p_gnd; load_gnd_on == !$past(gnd_loss, 3); endproperty
    a_gnd: assert property (p_gnd) else $error("ground path wrong");
    c_tout: cover property ($rose(timeout_flag));
    c_wake: cover property ($rose(inh_on));
    c_hv: cover property (bus_hv_level && bus_line_oe);
endmodule // swbm_checker

bind swbm_core swbm_checker #(.TOUT_CYCLES(TOUT_CYCLES)) swbm_checker_inst (
    .ref_clk(ref_clk), .rst_n(rst_n), .tx_cmd_n(tx_cmd_n),
    .tx_cmd_pu_sense(tx_cmd_pu_sense), .bus_dom_sense(bus_dom_sense),
    .gnd_loss(gnd_loss), .bus_line_oe(bus_line_oe),
    .bus_hv_level(bus_hv_level), .wave_shape_en(wave_shape_en),
    .rx_data(rx_data), .load_gnd_on(load_gnd_on), .inh_on(inh_on),
    .timeout_flag(timeout_flag), .mode_now(mode_now)
);

// file: bench/swbm_ctl_model.sv
`timescale 1ns/1ps
module swbm_ctl_model (
    input wire logic ref_clk,
    input wire logic tx_req,
    input wire logic float_req,
    input wire logic [1:0] mode_req,
    output logic tx_cmd_n,
    output logic tx_cmd_pu_sense,
    output logic mode_select_first,
    output logic mode_select_second
);
    localparam int BIT_CYC = 750; // 30 us bit at 25 MHz
    logic bit_dom = 1'h0;
    // a released pin rises through the pull-up
    assign tx_cmd_n = float_req ? 1'h1 : !(tx_req || bit_dom);
    assign tx_cmd_pu_sense = !float_req;
    assign mode_select_first = mode_req[0];
    assign mode_select_second = mode_req[1];
    task automatic send_bits(input logic [3:0] b);
        for (int i = 3; i >= 0; i--)
        begin
            @(negedge ref_clk);
            bit_dom = !b[i];
            repeat (BIT_CYC - 1) @(negedge ref_clk);
        end
        @(negedge ref_clk);
        bit_dom = 1'h0;
    endtask
endmodule // swbm_ctl_model

// file: bench/tb.sv
`timescale 1ns/1ps
module tb;
    import swbm_pkg::*;
    localparam int unsigned TOUT = 50;
    localparam int unsigned WUF = 10;
    localparam int unsigned SLP = 100;
    logic ref_clk = 1'h0;
    logic rst_n = 1'h0;
    logic tx_req = 1'h0;
    logic float_req = 1'h0;
    logic [1:0] mode_req = 2'h0;
    logic ext_dom = 1'h0;
    logic hv = 1'h0;
    logic gnd_loss = 1'h0;
    logic ce = 1'h1;
    logic tx_cmd_n, tx_cmd_pu_sense, msf, mss, bus_line_o, bus_line_oe;
    logic bus_hv_level, wave_shape_en, rx_data, load_gnd_on, inh_on;
    logic timeout_flag;
    logic [1:0] mode_now;
    int n_mismatch = 0;
    int checks_done = 0;
    int cyc_cnt = 0;
    always #20 ref_clk = ~ref_clk;
    swbm_ctl_model swbm_ctl_model_inst (.ref_clk(ref_clk), .tx_req(tx_req),
        .float_req(float_req), .mode_req(mode_req), .tx_cmd_n(tx_cmd_n),
        .tx_cmd_pu_sense(tx_cmd_pu_sense), .mode_select_first(msf),
        .mode_select_second(mss));
    // bus sees our driver plus other nodes
    swbm_core #(.TOUT_CYCLES(TOUT), .WUF_CYCLES(WUF), .SLEEP_CYCLES(SLP))
    swbm_core_inst (.ref_clk(ref_clk), .rst_n(rst_n), .ce(ce),
        .tx_cmd_n(tx_cmd_n), .tx_cmd_pu_sense(tx_cmd_pu_sense),
        .mode_select_first(msf), .mode_select_second(mss),
        .bus_dom_sense(bus_line_oe | ext_dom),
        .bus_hv_sense(hv | (bus_line_oe & bus_hv_level)),
        .gnd_loss(gnd_loss), .bus_line_o(bus_line_o),
        .bus_line_oe(bus_line_oe), .bus_hv_level(bus_hv_level),
        .wave_shape_en(wave_shape_en), .rx_data(rx_data),
        .load_gnd_on(load_gnd_on), .inh_on(inh_on),
        .timeout_flag(timeout_flag), .mode_now(mode_now));
    task automatic chk(input logic got, input logic exp);
        checks_done++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge ref_clk);
    endtask
    task automatic t_sleep();
        cyc(30);
        chk(inh_on, 1'h1);
        cyc(SLP);
        chk(inh_on, 1'h0);
        tx_req = 1'h1;
        ext_dom = 1'h1;
        cyc(8);
        chk(bus_line_oe, 1'h0);
        chk(rx_data, 1'h1);
        tx_req = 1'h0;
        ext_dom = 1'h0;
        $display("sleep done");
    endtask
    task automatic t_wake();
        hv = 1'h1;
        cyc(5);
        hv = 1'h0;
        cyc(6);
        chk(inh_on, 1'h0);
        hv = 1'h1;
        cyc(WUF + 8);
        chk(inh_on, 1'h1);
        chk(rx_data, 1'h0);
        hv = 1'h0;
        cyc(SLP + 10);
        chk(inh_on, 1'h0);
        $display("wake done");
    endtask
    task automatic t_modes();
        logic [1:0] m;
        for (int i = 1; i < 4; i++)
        begin
            m = 2'(i);
            mode_req = m;
            cyc(6);
            chk(inh_on, 1'h1);
            chk(mode_now[0], m[0]);
            chk(mode_now[1], m[1]);
            chk(wave_shape_en, m != MODE_HS);
            tx_req = 1'h1;
            cyc(8);
            chk(bus_line_oe, 1'h1);
            chk(bus_line_o, 1'h1);
            chk(bus_hv_level, m == MODE_HIGH_VOLTAGE_WAKEUP);
            chk(rx_data, 1'h0);
            tx_req = 1'h0;
            cyc(8);
            chk(bus_line_oe, 1'h0);
            chk(bus_line_o, 1'h0);
            ext_dom = 1'h1;
            cyc(8);
            chk(rx_data, 1'h0);
            ext_dom = 1'h0;
            cyc(8);
            chk(rx_data, 1'h1);
        end
        $display("modes done");
    endtask
    task automatic t_tout();
        float_req = 1'h1;
        cyc(8);
        chk(bus_line_oe, 1'h0);
        float_req = 1'h0;
        tx_req = 1'h1;
        cyc(30);
        tx_req = 1'h0;
        cyc(4);
        tx_req = 1'h1;
        cyc(TOUT - 5);
        chk(bus_line_oe, 1'h1);
        chk(timeout_flag, 1'h0);
        cyc(15);
        chk(timeout_flag, 1'h1);
        chk(bus_line_oe, 1'h0);
        tx_req = 1'h0;
        cyc(4);
        tx_req = 1'h1;
        cyc(6);
        chk(bus_line_oe, 1'h1);
        tx_req = 1'h0;
        cyc(8);
        $display("timeout done");
    endtask
    task automatic t_misc();
        gnd_loss = 1'h1;
        cyc(3);
        chk(load_gnd_on, 1'h0);
        gnd_loss = 1'h0;
        cyc(3);
        chk(load_gnd_on, 1'h1);
        swbm_ctl_model_inst.send_bits(4'h6);
        cyc(8);
        chk(rx_data, 1'h1);
        ce = 1'h0;
        mode_req = 2'h1;
        cyc(6);
        chk(mode_now[1], 1'h1);
        chk(wave_shape_en, 1'h1);
        ce = 1'h1;
        cyc(6);
        chk(mode_now[0], 1'h1);
        chk(mode_now[1], 1'h0);
        chk(wave_shape_en, 1'h0);
        $display("misc done");
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // ceiling well above the planned run length
    always @(posedge ref_clk)
    begin
        cyc_cnt++;
        if (cyc_cnt == 20000)
        begin
            n_mismatch++;
            final_report();
        end
    end
    initial
    begin
        cyc(5);
        rst_n = 1'h1;
        t_sleep();
        t_wake();
        t_modes();
        t_tout();
        t_misc();
        final_report();
    end
endmodule // tb
